// file: hdl/mt_params.svh
/*
  constants for the modulo timer: register byte offsets, field positions,
  reset values and response codes. assumes inclusion by mt_timer and mt_timer_tb.
*/
`ifndef MT_PARAMS_SVH
`define MT_PARAMS_SVH
`define MT_OFS_SC        4'h0
`define MT_OFS_CLK       4'h4
`define MT_OFS_CNT       4'h8
`define MT_OFS_MOD       4'hc
`define MT_BIT_FLAG      7
`define MT_BIT_IRQEN     6
`define MT_BIT_CLEAR     5
`define MT_BIT_HALT      4
`define MT_SRC_LSB       4
`define MT_SRC_MSB       5
`define MT_PS_LSB        0
`define MT_PS_MSB        3
`define MT_PS_MAX        4'h8
`define MT_SRC_BUS       2'h0
`define MT_SRC_FIXED     2'h1
`define MT_SRC_PIN_FALL  2'h2
`define MT_SRC_PIN_RISE  2'h3
`define MT_RST_COUNT     8'h00
`define MT_RST_MOD       8'h00
`define MT_RST_HALT      1'b1
`define MT_FREE_WRAP     8'hff
`define MT_RESP_OKAY     2'h0
`define MT_RESP_SLVERR   2'h2
`endif

// file: hdl/mt_pkg.sv
/*
  types for the modulo timer: mode carrier and the state record.
  assumes mt_params.svh is found on the include path.
*/
package mt_pkg;
    // low-power and debug mode levels from the system controller
    typedef struct packed {
        logic wait_mode;
        logic stop_mode;
        logic debug_active;
        logic deep_wake_reset;
    } mt_mode_t;

    typedef struct packed {
        logic [7:0]  count;
        logic [7:0]  modulo;
        logic [1:0]  src;
        logic [3:0]  ps;
        logic        flag;
        logic        irq_en;
        logic        halt;
        logic        clr_armed;
        logic [7:0]  presc;
        logic        pin_s1;
        logic        pin_s2;
        logic        pin_d;
        logic        ffc_d;
        logic        aw_held;
        logic [3:0]  aw_ofs;
        logic        w_held;
        logic [31:0] wdata;
        logic [3:0]  wstrb;
        logic        awready;
        logic        wready;
        logic        arready;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        rvalid;
        logic [31:0] rdata;
        logic [1:0]  rresp;
        logic        irq;
    } mt_state_t;
endpackage

// file: hdl/mt_timer.sv
/*
  modulo timer: 8-bit up-counter with prescaled clock selection, overflow
  flag and interrupt request, reached over an AXI4-Lite slave port.
  assumes all inputs synchronous to aclk except ext_count_clock_pin,
  which is synchronised here. reset is synchronous, active low.

// Contract
// RULE1: 8-bit counter, free-running or modulo wrap
// RULE2: source 10 or 11 selects external pin
// RULE3: pin may also feed pwm timer
// RULE4: four prescaler sources, pin both edges
// RULE5: nine divide ratios, 1 through 256
// RULE6: keeps counting in wait mode
// RULE7: stop mode disables timer, no wake
// RULE8: deep stop wake restores reset state
// RULE9: shallow stop interrupt exit keeps state
// RULE10: debug suspends counting, resumes from held
// RULE11: external pin synchronised to bus clock
// RULE12: pin frequency at most bus over four
// RULE13: flag sets on wrap after modulo
// RULE14: flag clears after read-then-write-zero
// RULE15: clear bit or modulo write clears flag
// RULE16: enable bit gates flag onto request
// RULE17: software clears flag before enabling irq
// RULE18: clear bit write-only, zeroes counter
// RULE19: halt bit freezes count, reset sets
// RULE20: status bits 3:0 read zero
// RULE21: four 8-bit registers
// RULE22: prescale codes above 1000 divide 256
// RULE23: source encodings, unknown means bus clock
// RULE24: modulo zero free-runs, write clears
// RULE25: counts to modulo then wraps
// RULE26: one step per prescaler tick
*/
`timescale 1ns/1ps
`include "mt_params.svh"

module mt_timer (
    input  wire logic             aclk,
    input  wire logic             aresetn,
    input  wire logic [31:0]      s_axi_awaddr,
    input  wire logic             s_axi_awvalid,
    output logic                  s_axi_awready,
    input  wire logic [31:0]      s_axi_wdata,
    input  wire logic [3:0]       s_axi_wstrb,
    input  wire logic             s_axi_wvalid,
    output logic                  s_axi_wready,
    output logic [1:0]            s_axi_bresp,
    output logic                  s_axi_bvalid,
    input  wire logic             s_axi_bready,
    input  wire logic [31:0]      s_axi_araddr,
    input  wire logic             s_axi_arvalid,
    output logic                  s_axi_arready,
    output logic [31:0]           s_axi_rdata,
    output logic [1:0]            s_axi_rresp,
    output logic                  s_axi_rvalid,
    input  wire logic             s_axi_rready,
    input  wire logic             ext_count_clock_pin,
    input  wire logic             fixed_freq_clock,
    input  wire mt_pkg::mt_mode_t mode,
    output logic                  overflow_irq
);
    import mt_pkg::*;

    mt_state_t st;
    mt_state_t next_st;

    // 1 when the selected prescaler source has an edge this cycle
    function automatic logic src_edge(input logic [1:0] sel, input logic pin_now,
                                      input logic pin_old, input logic ffc_now,
                                      input logic ffc_old);
        case (sel)
            `MT_SRC_FIXED:    src_edge = ffc_now & ~ffc_old;
            `MT_SRC_PIN_FALL: src_edge = ~pin_now & pin_old;  // RULE2
            `MT_SRC_PIN_RISE: src_edge = pin_now & ~pin_old;  // RULE2
            default:          src_edge = 1'b1;                // RULE23
        endcase
    endfunction

    // low bits of the prescaler that must all be set for a tick
    function automatic logic [7:0] ps_mask(input logic [3:0] ps);
        logic [3:0] n;
        n = (ps > `MT_PS_MAX) ? `MT_PS_MAX : ps;              // RULE22
        ps_mask = 8'((9'h001 << n) - 9'h001);                  // RULE5
    endfunction

    // read data for a register offset, narrow registers in the low byte
    function automatic logic [31:0] reg_read(input mt_state_t s, input logic [3:0] ofs);
        logic [7:0] b;
        b = 8'h00;
        case (ofs)
            // clear bit and bits 3:0 read as zero
            `MT_OFS_SC:  b = {s.flag, s.irq_en, 1'b0, s.halt, 4'h0};  // RULE20 RULE18
            `MT_OFS_CLK: b = {2'h0, s.src, s.ps};
            `MT_OFS_CNT: b = s.count;
            `MT_OFS_MOD: b = s.modulo;
            default:     b = 8'h00;
        endcase
        reg_read = {24'h000000, b};
    endfunction

    function automatic logic ofs_ok(input logic [3:0] ofs);
        ofs_ok = (ofs == `MT_OFS_SC) || (ofs == `MT_OFS_CLK) ||
                 (ofs == `MT_OFS_CNT) || (ofs == `MT_OFS_MOD);  // RULE21
    endfunction

    logic       tick;
    logic       active;
    logic       wrap;
    logic       do_write;
    logic       do_read;
    logic [7:0] wbyte;
    logic       wr_sc;
    logic       wr_clk;
    logic       wr_mod;
    logic       hw_clear;
    logic       sw_clear;
    logic       set_flag;

    // next-state logic for the whole block
    always_comb
    begin
        next_st = st;
        tick = 1'b0;
        wrap = 1'b0;
        set_flag = 1'b0;
        sw_clear = 1'b0;
        wbyte = st.wdata[7:0];

        // two-flop synchroniser; only pin_s2 feeds edge detection
        next_st.pin_s1 = ext_count_clock_pin;  // RULE11 RULE3
        next_st.pin_s2 = st.pin_s1;            // RULE11
        next_st.pin_d  = st.pin_s2;
        next_st.ffc_d  = fixed_freq_clock;

        // write completes once both address and data are held
        do_write = st.aw_held && st.w_held && !st.bvalid;
        wr_sc  = do_write && st.wstrb[0] && (st.aw_ofs == `MT_OFS_SC);
        wr_clk = do_write && st.wstrb[0] && (st.aw_ofs == `MT_OFS_CLK);
        wr_mod = do_write && st.wstrb[0] && (st.aw_ofs == `MT_OFS_MOD);
        do_read = s_axi_arvalid && st.arready;

        // a counter reset comes from the clear bit or any modulo write
        hw_clear = (wr_sc && wbyte[`MT_BIT_CLEAR]) || wr_mod;  // RULE15 RULE18 RULE24

        // stop and debug freeze the prescaler and counter; wait mode does not
        active = !st.halt && !mode.stop_mode && !mode.debug_active;  // RULE6 RULE7 RULE10 RULE19

        // prescaler advances on each selected source edge
        if (active && src_edge(st.src, st.pin_s2, st.pin_d, fixed_freq_clock, st.ffc_d))  // RULE4
        begin
            next_st.presc = st.presc + 8'h01;
            tick = ((st.presc & ps_mask(st.ps)) == ps_mask(st.ps));  // RULE5
        end

        // one count per tick; wraps at modulo, or at all-ones when free
        if (tick)  // RULE26
        begin
            if (st.modulo != `MT_RST_MOD)
                wrap = (st.count == st.modulo);      // RULE25
            else
                wrap = (st.count == `MT_FREE_WRAP);  // RULE24 RULE1
            next_st.count = wrap ? `MT_RST_COUNT : st.count + 8'h01;  // RULE25
            set_flag = wrap;                                        // RULE13
        end

        // arm the flag clear when status is read while the flag is set
        if (do_read && (s_axi_araddr[3:0] == `MT_OFS_SC) && st.flag)  // RULE14
            next_st.clr_armed = 1'b1;

        // register writes; count register ignores writes
        if (wr_sc)
        begin
            next_st.irq_en = wbyte[`MT_BIT_IRQEN];
            next_st.halt   = wbyte[`MT_BIT_HALT];  // RULE19
            if (!wbyte[`MT_BIT_FLAG] && st.clr_armed)
                sw_clear = 1'b1;                   // RULE14
            next_st.clr_armed = 1'b0;
        end
        if (wr_clk)
        begin
            next_st.src = wbyte[`MT_SRC_MSB:`MT_SRC_LSB];
            next_st.ps  = wbyte[`MT_PS_MSB:`MT_PS_LSB];
        end
        if (wr_mod)
            next_st.modulo = wbyte;  // RULE24

        // clearing also restarts the prescaler so the first period is whole
        if (hw_clear)
        begin
            next_st.count = `MT_RST_COUNT;  // RULE18 RULE24
            next_st.presc = 8'h00;
        end

        // a new overflow wins over any clear in the same cycle
        if (set_flag)
            next_st.flag = 1'b1;            // RULE13
        else if (hw_clear || sw_clear)
            next_st.flag = 1'b0;            // RULE14 RULE15

        // request follows flag while enabled, in the same cycle
        next_st.irq = next_st.flag && next_st.irq_en;  // RULE16 RULE17

        // write channel: take address and data in either order
        if (s_axi_awvalid && st.awready)
        begin
            next_st.aw_held = 1'b1;
            next_st.aw_ofs  = s_axi_awaddr[3:0];
        end
        if (s_axi_wvalid && st.wready)
        begin
            next_st.w_held = 1'b1;
            next_st.wdata  = s_axi_wdata;
            next_st.wstrb  = s_axi_wstrb;
        end
        if (do_write)
        begin
            next_st.aw_held = 1'b0;
            next_st.w_held  = 1'b0;
            next_st.bvalid  = 1'b1;
            next_st.bresp   = ofs_ok(st.aw_ofs) ? `MT_RESP_OKAY : `MT_RESP_SLVERR;
        end
        if (st.bvalid && s_axi_bready)
            next_st.bvalid = 1'b0;
        next_st.awready = !next_st.aw_held && !next_st.bvalid;
        next_st.wready  = !next_st.w_held && !next_st.bvalid;

        // read channel: one cycle from address to data
        if (do_read)
        begin
            next_st.rvalid = 1'b1;
            next_st.rdata  = reg_read(st, s_axi_araddr[3:0]);
            next_st.rresp  = ofs_ok(s_axi_araddr[3:0]) ? `MT_RESP_OKAY : `MT_RESP_SLVERR;
        end
        if (st.rvalid && s_axi_rready)
            next_st.rvalid = 1'b0;
        next_st.arready = !next_st.rvalid;

        // waking from deep stop returns timer state to reset values
        if (mode.deep_wake_reset)  // RULE8
        begin
            next_st.count     = `MT_RST_COUNT;
            next_st.modulo    = `MT_RST_MOD;
            next_st.src       = `MT_SRC_BUS;
            next_st.ps        = 4'h0;
            next_st.flag      = 1'b0;
            next_st.irq_en    = 1'b0;
            next_st.halt      = `MT_RST_HALT;
            next_st.clr_armed = 1'b0;
            next_st.presc     = 8'h00;
            next_st.irq       = 1'b0;
        end
        // shallow stop left by interrupt changes nothing: state is simply held  // RULE9
    end

    // state register; reset values are constants only
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            st           <= '0;
            st.count     <= `MT_RST_COUNT;
            st.modulo    <= `MT_RST_MOD;
            st.halt      <= `MT_RST_HALT;  // RULE19
            st.awready   <= 1'b1;
            st.wready    <= 1'b1;
            st.arready   <= 1'b1;
        end
        else
        begin
            st <= next_st;
        end
    end

    // every output straight from the state register
    assign s_axi_awready = st.awready;
    assign s_axi_wready  = st.wready;
    assign s_axi_bvalid  = st.bvalid;
    assign s_axi_bresp   = st.bresp;
    assign s_axi_arready = st.arready;
    assign s_axi_rvalid  = st.rvalid;
    assign s_axi_rdata   = st.rdata;
    assign s_axi_rresp   = st.rresp;
    assign overflow_irq  = st.irq;
endmodule // mt_timer

// file: sim/mt_timer_monitor.sv
/* checker on the timer bus port: handshakes and read-back fields.
   assumes a bind to mt_timer and a synchronous active-low reset. */
`timescale 1ns/1ps

module mt_timer_monitor (
    input wire logic        aclk,
    input wire logic        aresetn,
    input wire logic [31:0] s_axi_araddr,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready,
    input wire logic        s_axi_awvalid,
    input wire logic        s_axi_awready,
    input wire logic        s_axi_wvalid,
    input wire logic        s_axi_wready,
    input wire logic [1:0]  s_axi_bresp,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready
);
    logic [3:0] rd_ofs;

    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);

    // offset of the read in flight, so its answer can be judged
    always_ff @(posedge aclk)
    begin
        if (s_axi_arvalid && s_axi_arready)
            rd_ofs <= s_axi_araddr[3:0];
    end

    chk_read_late: assert property (
        s_axi_arvalid && s_axi_arready |=> s_axi_rvalid) else $error("read answer late");
    chk_write_late: assert property (
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##[1:2] s_axi_bvalid)
        else $error("write answer late");
    chk_b_stands: assert property (
        s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write answer dropped");
    chk_r_stands: assert property (
        s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read answer dropped");
    chk_ar_refused: assert property (
        s_axi_rvalid |-> !s_axi_arready) else $error("read taken while busy");
    chk_aw_refused: assert property (
        s_axi_bvalid |-> !s_axi_awready && !s_axi_wready) else $error("write taken while busy");
    chk_upper_zero: assert property (
        s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0) else $error("upper read bits set");
    chk_status_zero: assert property (
        s_axi_rvalid && rd_ofs == 4'h0 |-> s_axi_rdata[5] == 1'b0 && s_axi_rdata[3:0] == 4'h0)
        else $error("status unused bits set");
endmodule // mt_timer_monitor

bind mt_timer mt_timer_monitor mt_timer_monitor_i (.*);

// file: sim/mt_pin_source.sv
/* external count clock source for the timer pin.
   assumes the bench gates it; it stands still while run is low. */
`timescale 1ns/1ps

module mt_pin_source #(parameter int HALF_NS = 53) (
    input wire logic run,
    output logic     pin
);
    initial pin = 1'b0;
    // half period above two bus cycles keeps the rate under a quarter of aclk
    always #(HALF_NS) if (run) pin = ~pin;
endmodule // mt_pin_source

// file: sim/mt_timer_tb.sv
/* self-checking bench for mt_timer over its bus port.
   assumes mt_pkg compiled first and mt_params.svh on the include path. */
`timescale 1ns/1ps
`include "mt_params.svh"

module mt_timer_tb;
    import mt_pkg::*;
    logic        aclk = 1'b0, aresetn = 1'b0, pin_run = 1'b0;
    logic [31:0] s_axi_awaddr = 32'h0, s_axi_wdata = 32'h0, s_axi_araddr = 32'h0;
    logic [3:0]  s_axi_wstrb = 4'hf;
    logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0]  s_axi_bresp, s_axi_rresp, rrsp, brsp;
    logic [31:0] s_axi_rdata, rdat, held;
    logic        ext_count_clock_pin, fixed_freq_clock, overflow_irq;
    logic [2:0]  ffc_div = 3'h0;
    mt_mode_t    mode = '0;
    int          num_errors = 0, checks = 0, rise = 0, fall = 0, i, n, e, s;
    logic [7:0]  tbl [10] = '{8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06, 8'h07, 8'h08,
                              8'h0f, 8'h10};

    mt_timer mt_timer_i (.*);
    mt_pin_source mt_pin_source_i (.run(pin_run), .pin(ext_count_clock_pin));

    always #10 aclk = ~aclk;
    // fixed clock with a rising edge every eight bus cycles
    always @(posedge aclk) ffc_div <= ffc_div + 3'h1;
    assign fixed_freq_clock = ffc_div[2];
    always @(posedge ext_count_clock_pin) rise++;
    always @(negedge ext_count_clock_pin) fall++;

    task automatic wrap_up;
        $display("checks %0d errors %0d", checks, num_errors);
        if (num_errors == 0 && checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // a wait that ran out is a mismatch and ends the run
    task automatic to(input bit ok);
        if (!ok)
        begin
            num_errors++;
            wrap_up;
        end
    endtask

    // address and data offered together, each released once taken
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge aclk);
        s_axi_awaddr <= {28'h0, a};
        s_axi_wdata <= {24'h0, d};
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        for (n = 0; n < 50 && s_axi_bvalid !== 1'b1; n++)
        begin
            @(posedge aclk);
            if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
            if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
        end
        brsp = s_axi_bresp;
        s_axi_bready <= 1'b0;
        to(n < 50);
    endtask

    task automatic rd(input logic [3:0] a);
        @(posedge aclk);
        s_axi_araddr <= {28'h0, a};
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        for (n = 0; n < 50 && s_axi_rvalid !== 1'b1; n++)
        begin
            @(posedge aclk);
            if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
        end
        rdat = s_axi_rdata;
        rrsp = s_axi_rresp;
        s_axi_rready <= 1'b0;
        to(n < 50);
    endtask

    task automatic rc(input logic [3:0] a, input logic [7:0] x);
        rd(a);
        chk("register", rdat, {24'h0, x});
    endtask

    task automatic wirq;
        for (n = 0; n < 400 && overflow_irq !== 1'b1; n++)
            @(posedge aclk);
        to(n < 400);
    endtask

    initial
    begin
        repeat (8) @(posedge aclk);
        aresetn <= 1'b1;
        rc(`MT_OFS_SC, 8'h10);
        rc(`MT_OFS_CLK, 8'h00);
        rc(`MT_OFS_CNT, 8'h00);
        rc(`MT_OFS_MOD, 8'h00);
        rd(4'h2);
        chk("resp", rrsp, `MT_RESP_SLVERR);
        // unmapped write is refused with an error code, mapped one is accepted
        wr(4'h2, 8'hff);
        chk("wresp", brsp, `MT_RESP_SLVERR);
        wr(`MT_OFS_MOD, 8'h00);
        chk("wresp", brsp, `MT_RESP_OKAY);
        // divide codes 1 through 8 and 15, and the fixed source, over a 500 cycle run
        for (i = 0; i < 10; i++)
        begin
            wr(`MT_OFS_SC, 8'h30);
            wr(`MT_OFS_CLK, tbl[i]);
            wr(`MT_OFS_SC, 8'h00);
            repeat (500) @(posedge aclk);
            wr(`MT_OFS_SC, 8'h10);
            rd(`MT_OFS_CNT);
            s = tbl[i][4] ? 3 : (tbl[i][3:0] > 8 ? 8 : tbl[i][3:0]);
            e = 500 >> s;
            chk("rate", rdat[7:0] + 2 >= e && rdat[7:0] <= e + 2, 1);
        end
        // pin falling then rising edges, counted one for one
        for (i = 0; i < 2; i++)
        begin
            wr(`MT_OFS_SC, 8'h30);
            wr(`MT_OFS_CLK, i ? 8'h30 : 8'h20);
            wr(`MT_OFS_SC, 8'h00);
            rise = 0;
            fall = 0;
            pin_run <= 1'b1;
            for (n = 0; n < 200 && rise < 20; n++)
                @(posedge aclk);
            pin_run <= 1'b0;
            repeat (10) @(posedge aclk);
            rd(`MT_OFS_CNT);
            chk("pin", rdat, i ? rise : fall);
        end
        wr(`MT_OFS_CLK, 8'h00);
        wr(`MT_OFS_MOD, 8'h05);
        wr(`MT_OFS_SC, 8'h00);
        repeat (20) @(posedge aclk);
        wr(`MT_OFS_SC, 8'h10);
        rd(`MT_OFS_CNT);
        chk("limit", rdat <= 5, 1);
        rc(`MT_OFS_SC, 8'h90);
        wr(`MT_OFS_SC, 8'h10);
        rc(`MT_OFS_SC, 8'h10);
        wr(`MT_OFS_SC, 8'h40);
        wirq;
        wr(`MT_OFS_SC, 8'h70);
        repeat (2) @(posedge aclk);
        chk("irq", overflow_irq, 0);
        rc(`MT_OFS_CNT, 8'h00);
        rc(`MT_OFS_SC, 8'h50);
        wr(`MT_OFS_SC, 8'h40);
        wirq;
        wr(`MT_OFS_MOD, 8'hff);
        rc(`MT_OFS_SC, 8'h40);
        rc(`MT_OFS_MOD, 8'hff);
        // wait keeps counting, stop and debug freeze the count
        for (i = 0; i < 3; i++)
        begin
            mode <= 4'h8 >> i;
            rd(`MT_OFS_CNT);
            held = rdat;
            rd(`MT_OFS_CNT);
            chk("mode", rdat !== held, i == 0);
        end
        mode <= 4'h1;
        @(posedge aclk);
        mode <= 4'h0;
        rc(`MT_OFS_SC, 8'h10);
        rc(`MT_OFS_MOD, 8'h00);
        wrap_up;
    end
endmodule // mt_timer_tb
